// File: include/osc_pkg.sv
package osc_pkg;
  // =====================================================================
  // Register indices; each register is one word, so its byte address is four times the index.
  localparam logic [11:0] OSC_IDX_IRQ_STATUS = 12'h001;
  localparam logic [11:0] OSC_IDX_IRQ_ENABLE = 12'h002;
  localparam logic [11:0] OSC_IDX_SAMPLE_CFG = 12'h012;
  localparam logic [11:0] OSC_IDX_PROX_THRESH = 12'h014;
  localparam logic [11:0] OSC_IDX_FILTER_CFG = 12'h016;
  localparam logic [11:0] OSC_IDX_PILOT_CUR = 12'h029;
  // =====================================================================
  // Register byte addresses.
  localparam logic [11:0] OSC_ADDR_IRQ_STATUS = OSC_IDX_IRQ_STATUS << 2;
  localparam logic [11:0] OSC_ADDR_IRQ_ENABLE = OSC_IDX_IRQ_ENABLE << 2;
  localparam logic [11:0] OSC_ADDR_SAMPLE_CFG = OSC_IDX_SAMPLE_CFG << 2;
  localparam logic [11:0] OSC_ADDR_PROX_THRESH = OSC_IDX_PROX_THRESH << 2;
  localparam logic [11:0] OSC_ADDR_FILTER_CFG = OSC_IDX_FILTER_CFG << 2;
  localparam logic [11:0] OSC_ADDR_PILOT_CUR = OSC_IDX_PILOT_CUR << 2;
  localparam logic [11:0] OSC_ADDR_SLOT_SEQ = 12'h100;
  localparam logic [11:0] OSC_ADDR_CONTROL = 12'h104;
  localparam logic [11:0] OSC_ADDR_LED_DRIVE = 12'h108;
  localparam logic [11:0] OSC_ADDR_STATE = 12'h10C;
  // =====================================================================
  // Field positions.
  localparam int OSC_PROX_BIT = 4;
  localparam int OSC_PF_EN_BIT = 7;
  localparam int OSC_PREDICTION_ORDER_BIT = 6;
  localparam int OSC_PROX_SHIFT = 11;
  localparam logic [3:0] OSC_PIN_MODE_ONESHOT = 4'hA;
  localparam logic [3:0] OSC_SLOT_MUX_FIRST = 4'hA;
  localparam logic [3:0] OSC_SLOT_MUX_LAST = 4'hC;
  // =====================================================================
  // Reset values.
  localparam logic [7:0] OSC_RST_REG = 8'h00;
  localparam logic [7:0] OSC_RST_SLOTS = 8'h21;
  // =====================================================================
  // Timing, ref_clk at 10 MHz.
  localparam int OSC_CLK_HZ = 10_000_000;
  localparam int OSC_POWERUP_US = 20;
  localparam int OSC_EXPOSE_US = 60;
  localparam int OSC_POWERUP_CYC = (OSC_POWERUP_US * (OSC_CLK_HZ / 1_000_000));
  localparam int OSC_EXPOSE_CYC = (OSC_EXPOSE_US * (OSC_CLK_HZ / 1_000_000));
  localparam int OSC_PROX_SPS = 8;
  localparam int OSC_PROX_PERIOD_CYC = OSC_CLK_HZ / OSC_PROX_SPS;
  localparam int OSC_BASE_PERIOD_CYC = OSC_CLK_HZ / 25;

  typedef enum {OSC_IDLE, OSC_POWERUP, OSC_EXPOSE, OSC_CONVERT, OSC_PUSH, OSC_WAIT} osc_state_t;

  typedef struct packed {
    logic outlier_filter_enable;
    logic prediction_order;
    logic [1:0] tc;
    logic [1:0] init;
    logic [1:0] mult;
  } osc_filter_cfg_t;

  typedef struct packed {
    logic valid;
    logic [18:0] data;
  } osc_sample_t;
endpackage

// File: logic/osc_sample_control.sv
`timescale 1ns/1ns
// Overview of operation
// - In pin mode 1010 a sync falling edge starts power-up then one sample.
// - After the sample is pushed out, wait idle for the next sync pulse.
// - Mux select driven only in pin mode 1010: low during exposures of slots coded 0xA-0xC, else high.
// - Mux select released when no slot uses codes 0xA-0xC.
// - Sample period and exposure times come from internal counters.
// - First slot below threshold sets proximity flag and enters proximity mode.
// - Proximity mode uses pilot current, 8 sps and low-power mode.
// - Pilot measurement above threshold sets flag, returns to normal rate and drive.
// - Both proximity transitions happen without host action.
// - Proximity works only on first photodiode with no external mux.
// - In proximity mode only the first slot is exposed.
// - One threshold count equals 2048 conversion LSBs.
// - Outlier filter off after reset; enabled by bit 7 at 0x16.
// - Error is absolute conversion minus prediction; outlier when above threshold.
// - Prediction is previous value or linear fit over last four outputs.
// - Threshold is filtered error times 4, 8, 16 or 32.
// - Error IIR time constant 8-64 samples; initial value selectable.
// - Outliers are replaced by the prediction, others pass.
module osc_sample_control
  import osc_pkg::*;
#(
  parameter int POWERUP_CYC = OSC_POWERUP_CYC,
  parameter int EXPOSE_CYC = OSC_EXPOSE_CYC,
  parameter int PROX_PERIOD_CYC = OSC_PROX_PERIOD_CYC,
  parameter int BASE_PERIOD_CYC = OSC_BASE_PERIOD_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sync pin and mux select pin.
  input wire logic sync_input_pin,
  output logic mux_select_pin_o,
  output logic mux_select_pin_oe_n,
  // Converter result from the analog front end.
  input wire logic conv_valid,
  input wire logic [18:0] conv_data,
  input wire logic first_photodiode_input,
  // Front-end controls and sample output.
  output logic [7:0] led_current,
  output logic low_power,
  output logic [2:0] active_slot,
  output osc_sample_t sample_out
);
  // =====================================================================
  // Registers.
  logic [7:0] irq_status_r, irq_enable_r, sample_cfg_r, prox_thresh_r;
  logic [7:0] pilot_cur_r, led_drive_r, control_r;
  logic [23:0] slot_seq_r;
  osc_filter_cfg_t fcfg_r;
  logic prox_mode_r;
  osc_state_t state_r;
  logic [31:0] rdata_nxt;
  logic wr, rd_ok;
  logic prox_event;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;

  function automatic logic slot_mux(input logic [3:0] c);
    slot_mux = (c >= OSC_SLOT_MUX_FIRST) && (c <= OSC_SLOT_MUX_LAST);
  endfunction

  always_comb begin
    rd_ok = 1'b1;
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      OSC_ADDR_IRQ_STATUS: rdata_nxt[7:0] = irq_status_r;
      OSC_ADDR_IRQ_ENABLE: rdata_nxt[7:0] = irq_enable_r;
      OSC_ADDR_SAMPLE_CFG: rdata_nxt[7:0] = sample_cfg_r;
      OSC_ADDR_PROX_THRESH: rdata_nxt[7:0] = prox_thresh_r;
      OSC_ADDR_FILTER_CFG: rdata_nxt[7:0] = fcfg_r;
      OSC_ADDR_PILOT_CUR: rdata_nxt[7:0] = pilot_cur_r;
      OSC_ADDR_SLOT_SEQ: rdata_nxt[23:0] = slot_seq_r;
      OSC_ADDR_CONTROL: rdata_nxt[7:0] = control_r;
      OSC_ADDR_LED_DRIVE: rdata_nxt[7:0] = led_drive_r;
      OSC_ADDR_STATE: rdata_nxt[3:0] = {prox_mode_r, (state_r == OSC_IDLE), 2'b00};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? rdata_nxt : prdata;
      pslverr <= psel && !penable && !rd_ok;
    end
  end

  // Configuration writes; the status register reads and clears on write of one.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_enable_r <= OSC_RST_REG;
      sample_cfg_r <= OSC_RST_REG;
      prox_thresh_r <= OSC_RST_REG;
      fcfg_r <= OSC_RST_REG;
      pilot_cur_r <= OSC_RST_REG;
      led_drive_r <= OSC_RST_REG;
      control_r <= OSC_RST_REG;
      slot_seq_r <= {16'h0000, OSC_RST_SLOTS};
    end else if (wr) begin
      unique case (paddr)
        OSC_ADDR_IRQ_ENABLE: irq_enable_r <= pwdata[7:0];
        OSC_ADDR_SAMPLE_CFG: sample_cfg_r <= pwdata[7:0];
        OSC_ADDR_PROX_THRESH: prox_thresh_r <= pwdata[7:0];
        OSC_ADDR_FILTER_CFG: fcfg_r <= pwdata[7:0];
        OSC_ADDR_PILOT_CUR: pilot_cur_r <= pwdata[7:0];
        OSC_ADDR_LED_DRIVE: led_drive_r <= pwdata[7:0];
        OSC_ADDR_CONTROL: control_r <= pwdata[7:0];
        OSC_ADDR_SLOT_SEQ: slot_seq_r <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // A new proximity event wins over a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_status_r <= OSC_RST_REG;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == OSC_PROX_BIT && prox_event) begin
          irq_status_r[i] <= 1'b1;
        end else if (wr && paddr == OSC_ADDR_IRQ_STATUS && pwdata[i]) begin
          irq_status_r[i] <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // Sync pin synchroniser and sequencer.
  logic sync_s1_r, sync_s2_r, sync_s3_r;
  logic single_sample_sync, sync_fall;
  logic [31:0] cnt_r;
  logic [2:0] slot_r;
  logic [2:0] nslots;
  logic any_mux;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync_s1_r <= 1'b1;
      sync_s2_r <= 1'b1;
      sync_s3_r <= 1'b1;
    end else begin
      sync_s1_r <= sync_input_pin;
      sync_s2_r <= sync_s1_r;
      sync_s3_r <= sync_s2_r;
    end
  end

  assign single_sample_sync = (control_r[3:0] == OSC_PIN_MODE_ONESHOT);
  assign sync_fall = sync_s3_r && !sync_s2_r;

  // Active slot count: first zero code ends the sequence.
  always_comb begin
    nslots = 3'd6;
    for (int i = 5; i >= 0; i--) begin
      if (slot_seq_r[4*i +: 4] == 4'h0) begin
        nslots = 3'(i);
      end
    end
    any_mux = 1'b0;
    for (int i = 0; i < 6; i++) begin
      any_mux = any_mux || slot_mux(slot_seq_r[4*i +: 4]);
    end
  end

  logic sample_done;
  assign sample_done = (state_r == OSC_PUSH);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= OSC_IDLE;
      cnt_r <= 32'h0000_0000;
      slot_r <= 3'd0;
    end else begin
      unique case (state_r)
        OSC_IDLE: begin
          slot_r <= 3'd0;
          cnt_r <= 32'h0000_0000;
          if (nslots != 3'd0 && (single_sample_sync ? sync_fall : 1'b1)) begin
            state_r <= OSC_POWERUP;
          end
        end
        OSC_POWERUP: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r == 32'(POWERUP_CYC - 1)) begin
            cnt_r <= 32'h0000_0000;
            state_r <= OSC_EXPOSE;
          end
        end
        OSC_EXPOSE: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r == 32'(EXPOSE_CYC - 1)) begin
            cnt_r <= 32'h0000_0000;
            state_r <= OSC_CONVERT;
          end
        end
        OSC_CONVERT: begin
          if (conv_valid) begin
            // A first-slot result that flips the proximity mode also ends the sample,
            // so the mode never sees a slot past the first.
            if (slot_r + 3'd1 >= nslots || prox_mode_r || prox_event) begin
              state_r <= OSC_PUSH;
            end else begin
              slot_r <= slot_r + 3'd1;
              state_r <= OSC_EXPOSE;
            end
          end
        end
        OSC_PUSH: begin
          cnt_r <= 32'h0000_0000;
          state_r <= single_sample_sync ? OSC_IDLE : OSC_WAIT;
        end
        OSC_WAIT: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r >= 32'(prox_mode_r ? PROX_PERIOD_CYC : BASE_PERIOD_CYC >> sample_cfg_r[2:0]))
          begin
            state_r <= OSC_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // Mux select and LED drive.
  logic [3:0] cur_code;
  assign cur_code = slot_seq_r[4*slot_r +: 4];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mux_select_pin_o <= 1'b1;
      mux_select_pin_oe_n <= 1'b1;
      led_current <= 8'h00;
      low_power <= 1'b0;
      active_slot <= 3'd0;
    end else begin
      mux_select_pin_oe_n <= !(single_sample_sync && any_mux);
      mux_select_pin_o <= !((state_r == OSC_EXPOSE) && slot_mux(cur_code));
      led_current <= prox_mode_r && slot_r == 3'd0 ? pilot_cur_r : led_drive_r;
      low_power <= prox_mode_r;
      active_slot <= slot_r;
    end
  end

  // =====================================================================
  // Proximity detection on first-slot results.
  logic first_result, prox_ok, below, above;
  logic [18:0] prox_level;
  assign first_result = (state_r == OSC_CONVERT) && conv_valid && (slot_r == 3'd0);
  assign prox_ok = irq_enable_r[OSC_PROX_BIT] && first_photodiode_input &&
                   !slot_mux(slot_seq_r[3:0]);
  assign prox_level = 19'(prox_thresh_r) << OSC_PROX_SHIFT;
  assign below = conv_data < prox_level;
  // A result equal to the threshold changes the mode in neither direction.
  assign above = conv_data > prox_level;
  assign prox_event = first_result && prox_ok && (prox_mode_r ? above : below);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prox_mode_r <= 1'b0;
    end else if (!irq_enable_r[OSC_PROX_BIT]) begin
      prox_mode_r <= 1'b0;
    end else if (prox_event) begin
      prox_mode_r <= !prox_mode_r;
    end
  end

  // =====================================================================
  // Outlier detect-and-replace filter on first-slot conversions.
  logic [18:0] hist_r [4];
  logic [22:0] lpf_r;
  logic pf_en_d_r, primed_r;
  logic [21:0] pred_w;
  logic [18:0] pred, err;
  logic [27:0] thresh;
  logic outlier;

  // Linear least-squares fit over four points, extrapolated one step.
  always_comb begin
    // The fit works out to h0 + (h1 - h3) / 2; pred_w holds twice that value.
    pred_w = 22'(2 * hist_r[0]) + 22'(hist_r[1]) - 22'(hist_r[3]);
    if (!fcfg_r.prediction_order) begin
      pred = hist_r[0];
    end else if (pred_w[21]) begin
      pred = 19'h00000;
    end else if (pred_w[20]) begin
      pred = 19'h7FFFF;
    end else begin
      pred = pred_w[19:1];
    end
    err = conv_data > pred ? conv_data - pred : pred - conv_data;
    // Wide enough for the largest multiplier, so a large filtered error cannot wrap.
    thresh = 28'(lpf_r) << (3'd2 + 3'(fcfg_r.mult));
    outlier = fcfg_r.outlier_filter_enable && primed_r && (28'(err) << 4) > thresh;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pf_en_d_r <= 1'b0;
      primed_r <= 1'b0;
      lpf_r <= 23'h0;
      for (int i = 0; i < 4; i++) hist_r[i] <= 19'h0;
    end else begin
      pf_en_d_r <= fcfg_r.outlier_filter_enable;
      if (fcfg_r.outlier_filter_enable && !pf_en_d_r) begin
        primed_r <= 1'b0;
        lpf_r <= 23'(fcfg_r.init) << 12;
      end else if (first_result && fcfg_r.outlier_filter_enable) begin
        primed_r <= 1'b1;
        // The filtered error is held scaled by 16; the step is 1/2^(3+tc). The priming
        // sample has no real prediction, so it leaves the initial value alone.
        if (primed_r) begin
          lpf_r <= lpf_r + 23'((25'(err) << 4) >> (3 + fcfg_r.tc)) -
                   23'(lpf_r >> (3 + fcfg_r.tc));
        end
        hist_r[0] <= !primed_r ? conv_data : (outlier ? pred : conv_data);
        for (int i = 1; i < 4; i++) hist_r[i] <= !primed_r ? conv_data : hist_r[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sample_out <= '0;
    end else begin
      sample_out.valid <= first_result || ((state_r == OSC_CONVERT) && conv_valid);
      sample_out.data <= (first_result && outlier) ? pred : conv_data;
    end
  end

  // =====================================================================
  // Assertions.
  prox_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    prox_event |=> irq_status_r[OSC_PROX_BIT]) else $error("proximity flag not set");
  mode_toggle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    prox_event && irq_enable_r[OSC_PROX_BIT] |=> prox_mode_r != $past(prox_mode_r))
    else $error("proximity mode did not change");
  oneshot_start_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_r == OSC_IDLE && single_sample_sync && !sync_fall |=> state_r == OSC_IDLE)
    else $error("single_sample_sync started without sync");
  oneshot_wait_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_r == OSC_PUSH && single_sample_sync |=> state_r == OSC_IDLE)
    else $error("single_sample_sync did not return idle");
  mux_release_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !any_mux |=> mux_select_pin_oe_n) else $error("mux pin driven without mux slot");
  mux_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_r == OSC_EXPOSE && slot_mux(cur_code) |=> !mux_select_pin_o)
    else $error("mux select not low");
  prox_slot_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    prox_mode_r |-> slot_r == 3'd0) else $error("slot past first in proximity");
  pf_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !fcfg_r.outlier_filter_enable && conv_valid |=> sample_out.data == $past(conv_data))
    else $error("disabled filter altered data");
  pf_replace_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    first_result && outlier |=> sample_out.data == $past(pred))
    else $error("outlier not replaced");
  expose_len_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(state_r == OSC_EXPOSE) |-> (state_r == OSC_EXPOSE) [*8])
    else $error("exposure ended early");
  prox_enter_c: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(prox_mode_r));
  prox_leave_c: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(prox_mode_r));
  oneshot_c: cover property (@(posedge ref_clk) disable iff (!resetn) single_sample_sync && sample_done);
  outlier_c: cover property (@(posedge ref_clk) disable iff (!resetn) first_result && outlier);
endmodule

// File: tb/osc_frontend_model.sv
`timescale 1ns/1ns
// ==========================================================
// Front-end model: converter results and the sync source.
module osc_frontend_model #(
  parameter int GAP = 3
) (
  // Clock.
  input wire logic ref_clk,
  // Sync pin and converter result.
  output logic sync_input_pin,
  output logic conv_valid,
  output logic [18:0] conv_data
);
  logic [18:0] level;
  logic slow;
  int cnt;
  initial begin
    level = 19'h003E8;
    slow = 1'b0;
    cnt = 0;
    sync_input_pin = 1'b1;
    conv_valid = 1'b0;
    conv_data = 19'h00000;
  end
  // Data toggles between results, so a stale value is never taken for a fresh one.
  always @(posedge ref_clk) begin
    cnt <= (cnt >= (slow ? 4 * GAP : GAP)) ? 0 : cnt + 1;
    conv_valid <= (cnt == 0);
    conv_data <= (cnt == 0) ? level : ~conv_data;
  end
  // The pin idles high; only the falling edge of the pulse matters.
  task automatic sync_pulse();
    @(posedge ref_clk);
    sync_input_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    sync_input_pin <= 1'b1;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import osc_pkg::*;
  // ==========================================================
  // Signals.
  localparam int PU = 10;
  localparam int EX = 10;
  localparam int PP = 120;
  localparam int BP = 40;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, fpi, e, clr;
  logic sync_pin, conv_valid, mux_o, mux_oe_n, low_power;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [18:0] conv_data, d;
  logic [7:0] led_current;
  logic [7:0] led_seen = 8'h00;
  logic [7:0] mask_lp = 8'h00;
  logic [7:0] mask_nm = 8'h00;
  logic [2:0] active_slot;
  osc_sample_t sample_out;
  int err_total, n_compared, cyc, last_v, gap, n_samp, mux_low, base, mux_base;
  logic [11:0] regs [7] = '{OSC_ADDR_IRQ_STATUS, OSC_ADDR_IRQ_ENABLE, OSC_ADDR_SAMPLE_CFG,
    OSC_ADDR_PROX_THRESH, OSC_ADDR_FILTER_CFG, OSC_ADDR_PILOT_CUR, OSC_ADDR_SLOT_SEQ};
  // ==========================================================
  // Design and front-end model.
  osc_sample_control #(.POWERUP_CYC(PU), .EXPOSE_CYC(EX), .PROX_PERIOD_CYC(PP),
    .BASE_PERIOD_CYC(BP)) osc_sample_control_i (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_input_pin(sync_pin), .mux_select_pin_o(mux_o), .mux_select_pin_oe_n(mux_oe_n),
    .conv_valid(conv_valid), .conv_data(conv_data), .first_photodiode_input(fpi),
    .led_current(led_current), .low_power(low_power), .active_slot(active_slot),
    .sample_out(sample_out));
  osc_frontend_model osc_frontend_model_i (.ref_clk(ref_clk), .sync_input_pin(sync_pin),
    .conv_valid(conv_valid), .conv_data(conv_data));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic get_s();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (sample_out.valid !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000) check(32'h0, 32'h1);
    d = sample_out.data;
  endtask
  task automatic feed(input logic [18:0] v, input logic [18:0] x, input logic chk);
    osc_frontend_model_i.level <= v;
    get_s();
    if (chk) check(d, x);
  endtask
  task automatic wait_lp(input logic v);
    int k;
    k = 0;
    while (low_power !== v && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    check(low_power, v);
  endtask
  // The monitor owns the masks; a request clears them at the following edge.
  task automatic clear_marks();
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Monitor.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (mux_oe_n === 1'b0 && mux_o === 1'b0) mux_low <= mux_low + 1;
    if (clr === 1'b1) begin
      mask_lp <= 8'h00;
      mask_nm <= 8'h00;
      led_seen <= 8'h00;
    end else begin
      if (led_current !== 8'h00) led_seen <= led_current;
      if (sample_out.valid === 1'b1 && low_power === 1'b1) mask_lp[active_slot] <= 1'b1;
      if (sample_out.valid === 1'b1 && low_power === 1'b0) mask_nm[active_slot] <= 1'b1;
    end
    if (sample_out.valid === 1'b1) begin
      gap <= cyc - last_v;
      last_v <= cyc;
      n_samp <= n_samp + 1;
    end
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    check(32'h0, 32'h1);
    tally_and_finish();
  end
  // ==========================================================
  // Sequence.
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fpi = 1'b1;
    clr = 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      check(q, (i == 6) ? OSC_RST_SLOTS : OSC_RST_REG);
    end
    for (int i = 1; i < 6; i++) begin
      apb(1'b1, regs[i], 32'hFFFFFFA5);
      apb(1'b0, regs[i], 32'h0);
      check(q, 32'h000000A5);
      apb(1'b1, regs[i], 32'h0);
    end
    apb(1'b1, 12'h0FC, 32'h1);
    check(e, 1'b1);
    apb(1'b0, 12'h0FC, 32'h0);
    check(e, 1'b1);
    check(q, 32'h0);
    // Single_sample_sync runs, one for each mux code.
    apb(1'b1, OSC_ADDR_CONTROL, 32'(OSC_PIN_MODE_ONESHOT));
    for (int c = 10; c < 13; c++) begin
      apb(1'b1, OSC_ADDR_SLOT_SEQ, 32'(c * 16 + 1));
      repeat (300) @(posedge ref_clk);
      check(mux_oe_n, 1'b0);
      base = n_samp;
      mux_base = mux_low;
      osc_frontend_model_i.sync_pulse();
      repeat (300) @(posedge ref_clk);
      check(n_samp - base, 2);
      check(mux_low - mux_base >= EX && mux_low - mux_base <= EX + 8, 1'b1);
      apb(1'b0, OSC_ADDR_STATE, 32'h0);
      check(q[2], 1'b1);
    end
    apb(1'b1, OSC_ADDR_SLOT_SEQ, 32'h21);
    repeat (300) @(posedge ref_clk);
    check(mux_oe_n, 1'b1);
    // Outlier filter in continuous sampling.
    apb(1'b1, OSC_ADDR_CONTROL, 32'h0);
    apb(1'b1, OSC_ADDR_SLOT_SEQ, 32'h01);
    get_s();
    get_s();
    feed(19'd1000, 19'd1000, 1'b1);
    feed(19'd60000, 19'd60000, 1'b1);
    feed(19'd1000, 19'd1000, 1'b1);
    apb(1'b1, OSC_ADDR_FILTER_CFG, 32'h83);
    get_s();
    repeat (4) feed(19'd1000, 19'd1000, 1'b1);
    feed(19'd60000, 19'd1000, 1'b1);
    feed(19'd1000, 19'd0, 1'b0);
    apb(1'b1, OSC_ADDR_FILTER_CFG, 32'h0);
    apb(1'b1, OSC_ADDR_FILTER_CFG, 32'hCD);
    osc_frontend_model_i.slow <= 1'b1;
    get_s();
    for (int i = 0; i < 10; i++) feed(19'(1000 + 100 * i), 19'd0, 1'b0);
    feed(19'd50000, 19'd2000, 1'b1);
    osc_frontend_model_i.slow <= 1'b0;
    apb(1'b1, OSC_ADDR_FILTER_CFG, 32'h0);
    // Proximity: pilot current well below the normal drive.
    apb(1'b1, OSC_ADDR_SLOT_SEQ, 32'h21);
    apb(1'b1, OSC_ADDR_PROX_THRESH, 32'h2);
    apb(1'b1, OSC_ADDR_PILOT_CUR, 32'h05);
    apb(1'b1, OSC_ADDR_LED_DRIVE, 32'h80);
    fpi <= 1'b0;
    osc_frontend_model_i.level <= 19'd4095;
    apb(1'b1, OSC_ADDR_IRQ_ENABLE, 32'h10);
    repeat (600) @(posedge ref_clk);
    check(low_power, 1'b0);
    fpi <= 1'b1;
    wait_lp(1'b1);
    apb(1'b0, OSC_ADDR_IRQ_STATUS, 32'h0);
    check(q, 32'h10);
    apb(1'b1, OSC_ADDR_IRQ_STATUS, 32'h10);
    apb(1'b0, OSC_ADDR_IRQ_STATUS, 32'h0);
    check(q, 32'h0);
    get_s();
    clear_marks();
    get_s();
    get_s();
    @(posedge ref_clk);
    check(gap >= PP, 1'b1);
    check($countones(mask_lp), 1);
    check(led_seen, 8'h05);
    osc_frontend_model_i.level <= 19'd4097;
    wait_lp(1'b0);
    apb(1'b0, OSC_ADDR_IRQ_STATUS, 32'h0);
    check(q, 32'h10);
    get_s();
    clear_marks();
    repeat (3) get_s();
    @(posedge ref_clk);
    check(gap < PP, 1'b1);
    check($countones(mask_nm), 2);
    check(led_seen, 8'h80);
    tally_and_finish();
  end
endmodule
